// ---- rtl/pmdp_pkg.sv ----
`default_nettype none
// ============================================================
// Shared constants
package pmdp_pkg;
  // Descriptor table shape
  localparam int NUM_DESC = 64;
  localparam int DESC_IDX_W = 6;
  localparam int DESC_W = 32;
  localparam int LOG_W = 12;
  localparam int PHYS_W = 13;
  localparam int ATTR_W = 7;
  localparam int DESC_LOG_LSB = 20;
  localparam int DESC_PHYS_LSB = 7;
  // Attribute bit positions, high to low
  localparam int ATTR_VALID = 6;
  localparam int ATTR_REF = 5;
  localparam int ATTR_CHG = 4;
  localparam int ATTR_DESCENDING_WARN_FLAG = 3;
  localparam int ATTR_EXC = 2;
  localparam int ATTR_SYS = 1;
  localparam int ATTR_WP = 0;
  // Page size and warn window
  localparam int PAGE_OFF_W = 11;
  localparam int WARN_SPAN_BYTES = 128;
  localparam int WARN_LSB = $clog2(WARN_SPAN_BYTES);
  // Abort length in cycles
  localparam logic [2:0] ABORT_CYCLES = 3'h4;
  // Bus status codes
  localparam logic [3:0] ST_TRAP_ACK = 4'h4;
  localparam logic [2:0] ST_FETCH_TOP = 3'h6;
  // Command register selects
  localparam logic [3:0] SEL_MODE = 4'h0;
  localparam logic [3:0] SEL_DPTR = 4'h1;
  localparam logic [3:0] SEL_DBYTE = 4'h2;
  localparam logic [3:0] SEL_DESC = 4'h3;
  localparam logic [3:0] SEL_ATTR = 4'h4;
  localparam logic [3:0] SEL_CAUSE = 4'h5;
  localparam logic [3:0] SEL_FSEG = 4'h6;
  localparam logic [3:0] SEL_FOFF_HI = 4'h7;
  localparam logic [3:0] SEL_FOFF_LO = 4'h8;
  localparam logic [3:0] SEL_LF_SEG = 4'h9;
  localparam logic [3:0] SEL_LF_HI = 4'ha;
  localparam logic [3:0] SEL_LF_LO = 4'hb;
  localparam logic [3:0] SEL_CYC = 4'hc;
  localparam logic [3:0] SEL_CNT = 4'hd;
  // Mode register bits
  localparam int MODE_MASTER = 7;
  localparam int MODE_RELOC = 6;
  localparam int MODE_MULTI = 5;
  localparam int MODE_SIDE = 4;
  localparam logic [7:0] MODE_MASK = 8'hf7;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Trap cause bits
  localparam int CAUSE_WP = 0;
  localparam int CAUSE_SYS = 1;
  localparam int CAUSE_EXC = 2;
  localparam int CAUSE_FAULT = 3;
  localparam int CAUSE_WARN = 4;
  // Fetch codes share top three bits
  function automatic logic pmdp_is_fetch(input logic [3:0] st);
    pmdp_is_fetch = (st[3:1] == ST_FETCH_TOP);
  endfunction
endpackage
`default_nettype wire

// ---- rtl/pmdp_table_if.sv ----
`default_nettype none
// ============================================================
// Control to table link
interface pmdp_table_if;
  import pmdp_pkg::*;
  logic [LOG_W-1:0] key;         // Lookup key
  logic lookup_en;               // Capture a lookup
  logic hit;                     // Registered match
  logic [DESC_IDX_W-1:0] hit_idx;
  logic [PHYS_W-1:0] hit_base;
  logic [ATTR_W-1:0] hit_attr;
  logic upd_en;                  // Usage update
  logic upd_chg;
  logic [DESC_IDX_W-1:0] upd_idx;
  logic wr_en;                   // Command byte write
  logic wr_attr_only;
  logic [1:0] wr_byte;
  logic [DESC_IDX_W-1:0] wr_idx;
  logic [7:0] wr_data;
  logic [DESC_IDX_W-1:0] rd_idx; // Standing read pointer
  logic [DESC_W-1:0] rd_word;
  modport ctrl_side (output key, lookup_en, upd_en, upd_chg, upd_idx, wr_en,
    wr_attr_only, wr_byte, wr_idx, wr_data, rd_idx,
    input hit, hit_idx, hit_base, hit_attr, rd_word);
  modport table_side (input key, lookup_en, upd_en, upd_chg, upd_idx, wr_en,
    wr_attr_only, wr_byte, wr_idx, wr_data, rd_idx,
    output hit, hit_idx, hit_base, hit_attr, rd_word);
endinterface
`default_nettype wire

// ---- rtl/pmdp_desc_table.sv ----
`default_nettype none
// ============================================================
// Associative descriptor store
module pmdp_desc_table
  import pmdp_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  pmdp_table_if.table_side tbl
);
  logic [DESC_W-1:0] entry_reg [NUM_DESC];   // Descriptor words
  logic [DESC_W-1:0] entry_next [NUM_DESC];  // Next words
  logic [NUM_DESC-1:0] match;                // Compare vector
  logic any_hit;
  logic [DESC_IDX_W-1:0] first_idx;

  // ============================================================
  // Parallel compare of valid entries
  genvar g;
  generate
    for (g = 0; g < NUM_DESC; g++) begin : g_cmp
      // Invalid entries are excluded from the compare [RULE7] [RULE4]
      assign match[g] = entry_reg[g][ATTR_VALID] &&
        (entry_reg[g][DESC_LOG_LSB +: LOG_W] == tbl.key);
    end
  endgenerate

  // Lowest index wins if software loaded duplicates
  always_comb begin
    any_hit = 1'b0;
    first_idx = '0;
    for (int i = NUM_DESC - 1; i >= 0; i--) begin
      if (match[i]) begin
        any_hit = 1'b1;
        first_idx = DESC_IDX_W'(i);
      end
    end
  end

  // Byte writes, then usage flags
  always_comb begin
    for (int i = 0; i < NUM_DESC; i++) begin
      entry_next[i] = entry_reg[i];
      if (tbl.wr_en && tbl.wr_idx == DESC_IDX_W'(i)) begin
        if (tbl.wr_attr_only) begin
          // Top bit of the attribute byte is dropped [RULE6]
          entry_next[i][ATTR_W-1:0] = tbl.wr_data[ATTR_W-1:0];
        end else begin
          // Byte 0 is the top byte of the word [RULE18] [RULE6]
          entry_next[i][{~tbl.wr_byte, 3'b000} +: 8] = tbl.wr_data;
        end
      end
      // Applied after the write so a set is never lost [RULE12] [RULE11]
      if (tbl.upd_en && tbl.upd_idx == DESC_IDX_W'(i)) begin
        entry_next[i][ATTR_REF] = 1'b1;
        if (tbl.upd_chg) begin
          entry_next[i][ATTR_CHG] = 1'b1;
        end
      end
    end
  end

  // Storage of 64 descriptors [RULE3]
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < NUM_DESC; i++) begin
      if (!reset_n_in) begin
        entry_reg[i] <= '0;
      end else begin
        entry_reg[i] <= entry_next[i];
      end
    end
  end

  // Lookup result held
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      tbl.hit <= 1'b0;
      tbl.hit_idx <= '0;
      tbl.hit_base <= '0;
      tbl.hit_attr <= '0;
    end else if (tbl.lookup_en) begin
      tbl.hit <= any_hit;
      tbl.hit_idx <= first_idx;
      tbl.hit_base <= entry_reg[first_idx][DESC_PHYS_LSB +: PHYS_W];
      tbl.hit_attr <= entry_reg[first_idx][ATTR_W-1:0];
    end
  end

  // Read word follows the pointer one cycle late
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      tbl.rd_word <= '0;
    end else begin
      tbl.rd_word <= entry_reg[tbl.rd_idx];
    end
  end
endmodule
`default_nettype wire

// ---- rtl/pmdp_unit.sv ----
`default_nettype none
// Notes on behaviour
// (RULE1) Writes to low 128 bytes of warned page trap
// (RULE2) Warnings raise no abort and no suppress
// (RULE3) Sixty-four descriptors: 12 logical, 13 physical, 7 flags
// (RULE4) Match segment plus five top offset bits
// (RULE5) Flags: valid, ref, changed, warn, fetch, super, protect
// (RULE6) Attribute byte bit 7 ignored; otherwise physical
// (RULE7) Only valid descriptors join the compare
// (RULE8) Write to protected page is a violation
// (RULE9) Normal-mode access to supervisor page violates
// (RULE10) Non-fetch access to fetch-only page violates
// (RULE11) Clean write sets the page written flag
// (RULE12) Clean access sets the referenced flag
// (RULE13) Mode holds a 3-bit unit number
// (RULE14) Multi-table: translate only when side matches
// (RULE15) Relocation off passes address, top bit zero
// (RULE16) Master off: no translation, outputs released
// (RULE17) Pointer selects descriptor, auto-increments
// (RULE18) Byte counter: 0..2 address bytes, 3 flags
// (RULE19) Four-bit data count, frozen by abort
// (RULE20) Capture last fetch address at first event
// (RULE21) Capture faulting segment and offset
// (RULE22) Capture status, direction and mode of cycle
// (RULE23) Trap on violation, warning or page fault
// (RULE24) Violations raise abort, trap and suppress together
// (RULE25) Enabled when master, relocation and side agree
// (RULE26) Output top 16 bits of base plus offset
// (RULE27) Acknowledge drives line 8 + unit number
// ============================================================
// Translation, protection and command logic
module pmdp_unit
  import pmdp_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic chip_enable_in,
  input wire logic addr_strobe_in,
  input wire logic [6:0] seg_in,
  input wire logic [15:0] offset_in,
  input wire logic [3:0] status_in,
  input wire logic read_not_write_in,
  input wire logic normal_mode_in,
  output logic [15:0] phys_addr_out,
  output logic phys_addr_oe_out,
  output logic abort_req_out,
  output logic trap_req_out,
  output logic suppress_out,
  output logic [7:0] ack_ad_out,
  output logic [7:0] ack_ad_oe_out,
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire logic [3:0] cmd_sel_in,
  input wire logic [7:0] cmd_wdata_in,
  output logic [7:0] cmd_rdata_out
);
  // ============================================================
  // Table instance
  pmdp_table_if tbl ();

  pmdp_desc_table u_table (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .tbl(tbl)
  );

  // ============================================================
  // Control and status registers
  logic [7:0] mode_reg;                      // unit_mode_control
  logic [DESC_IDX_W-1:0] dptr_reg;           // descriptor_pointer
  logic [1:0] dbyte_reg;                     // descriptor_byte_counter
  logic [7:0] cause_reg;                     // trap_cause_flags
  logic [6:0] fseg_reg;                      // fault_segment_number
  logic [15:0] foff_reg;                     // fault_offset, two bytes
  logic [22:0] lfetch_reg;                   // last_fetch_address
  logic [22:0] fetch_shadow_reg;             // Most recent fetch seen
  logic [7:0] cyc_reg;                       // fault_cycle_status
  logic [3:0] count_reg;                     // data_transfer_count
  logic count_lock_reg;                      // Freeze after abort
  logic [2:0] abort_cnt_reg;                 // Abort cycles left
  logic trap_reg;                            // Pending trap request
  logic [15:0] phys_reg;
  logic phys_oe_reg;
  logic [7:0] ack_ad_reg;
  logic [7:0] ack_oe_reg;
  logic [7:0] rdata_reg;

  // Captured cycle, one clock behind the strobe
  logic s1_valid_reg;
  logic [6:0] s1_seg_reg;
  logic [15:0] s1_off_reg;
  logic [3:0] s1_st_reg;
  logic s1_rd_reg;
  logic s1_ns_reg;
  logic s1_drive_reg;                        // Unit owned the cycle
  logic s1_check_reg;                        // Translation active

  // ============================================================
  // Enable decode
  logic unit_master_on;
  logic relocation_on_flag;
  logic multi_table_flag;
  logic table_side_select;
  logic [2:0] unit_number_field;
  logic side_ok;
  logic drive_en;
  logic check_en;

  assign unit_master_on = mode_reg[MODE_MASTER];
  assign relocation_on_flag = mode_reg[MODE_RELOC];
  assign multi_table_flag = mode_reg[MODE_MULTI];
  assign table_side_select = mode_reg[MODE_SIDE];
  assign unit_number_field = mode_reg[2:0];                // [RULE13]
  // Side mismatch under multi-table keeps the unit silent [RULE14]
  assign side_ok = !multi_table_flag || (normal_mode_in == table_side_select);
  // Master flag gates everything, chip enable too [RULE16]
  assign drive_en = unit_master_on && chip_enable_in && side_ok;
  // Checking only while relocating [RULE25] [RULE15]
  assign check_en = drive_en && relocation_on_flag;

  // ============================================================
  // Lookup request to the table
  assign tbl.key = {seg_in, offset_in[15:PAGE_OFF_W]};     // [RULE4]
  assign tbl.lookup_en = addr_strobe_in;

  // Stage register for the cycle under evaluation
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      s1_valid_reg <= 1'b0;
      s1_seg_reg <= '0;
      s1_off_reg <= '0;
      s1_st_reg <= '0;
      s1_rd_reg <= 1'b1;
      s1_ns_reg <= 1'b0;
      s1_drive_reg <= 1'b0;
      s1_check_reg <= 1'b0;
    end else begin
      s1_valid_reg <= addr_strobe_in;
      // Fields only move on a strobe
      if (addr_strobe_in) begin
        s1_seg_reg <= seg_in;
        s1_off_reg <= offset_in;
        s1_st_reg <= status_in;
        s1_rd_reg <= read_not_write_in;
        s1_ns_reg <= normal_mode_in;
        s1_drive_reg <= drive_en;
        s1_check_reg <= check_en;
      end
    end
  end

  // ============================================================
  // Protection check
  logic is_fetch;
  logic is_ack;
  logic access;
  logic hit_ok;
  logic viol_wp;
  logic viol_sys;
  logic viol_exc;
  logic viol_any;
  logic page_fault;
  logic warn;
  logic abort_evt;
  logic trap_evt;
  logic clean_access;
  logic first_event;

  assign is_fetch = pmdp_is_fetch(s1_st_reg);
  assign is_ack = (s1_st_reg == ST_TRAP_ACK);
  // Acknowledge cycles are not memory references
  assign access = s1_valid_reg && s1_check_reg && !is_ack;
  assign hit_ok = access && tbl.hit;
  // Flag order fixed by the attribute layout [RULE5]
  assign viol_wp = hit_ok && !s1_rd_reg && tbl.hit_attr[ATTR_WP];       // [RULE8]
  assign viol_sys = hit_ok && s1_ns_reg && tbl.hit_attr[ATTR_SYS];      // [RULE9]
  assign viol_exc = hit_ok && !is_fetch && tbl.hit_attr[ATTR_EXC];      // [RULE10]
  assign viol_any = viol_wp || viol_sys || viol_exc;
  // No valid descriptor matched [RULE7]
  assign page_fault = access && !tbl.hit;
  // Lowest page bytes sit at the stack limit [RULE1]
  assign warn = hit_ok && !viol_any && !s1_rd_reg && tbl.hit_attr[ATTR_DESCENDING_WARN_FLAG] &&
    (s1_off_reg[PAGE_OFF_W-1:WARN_LSB] == '0);
  // Warnings stay out of the abort path [RULE2] [RULE24]
  assign abort_evt = viol_any || page_fault;
  assign trap_evt = abort_evt || warn;                      // [RULE23]
  assign clean_access = hit_ok && !viol_any;
  // Status capture keeps the first event only
  assign first_event = trap_evt && (cause_reg == RESET_BYTE);

  // Usage flags for a clean access [RULE12] [RULE11]
  assign tbl.upd_en = clean_access;
  assign tbl.upd_chg = !s1_rd_reg;
  assign tbl.upd_idx = tbl.hit_idx;

  // ============================================================
  // Address output
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      phys_reg <= '0;
      phys_oe_reg <= 1'b0;
    end else begin
      // Released whenever the unit is not selected [RULE16] [RULE14]
      phys_oe_reg <= drive_en;
      if (s1_valid_reg && s1_drive_reg && !is_ack) begin
        if (s1_check_reg) begin
          // Base joined to in-page offset, top 16 bits [RULE26]
          phys_reg <= tbl.hit ? {tbl.hit_base, s1_off_reg[PAGE_OFF_W-1:8]} : '0;
        end else begin
          // Pass through with zero top bit [RULE15]
          phys_reg <= {1'b0, s1_seg_reg, s1_off_reg[15:8]};
        end
      end
    end
  end

  assign phys_addr_out = phys_reg;
  assign phys_addr_oe_out = phys_oe_reg;

  // ============================================================
  // Abort and suppress run a fixed count
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      abort_cnt_reg <= '0;
    end else if (abort_evt) begin
      abort_cnt_reg <= ABORT_CYCLES;                       // [RULE24]
    end else if (abort_cnt_reg != '0) begin
      abort_cnt_reg <= abort_cnt_reg - 3'h1;
    end
  end

  // Suppress shares the abort window, so the store is blocked throughout
  assign abort_req_out = (abort_cnt_reg != '0);
  assign suppress_out = (abort_cnt_reg != '0);

  // Trap request until acknowledged; a new event beats the clear
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      trap_reg <= 1'b0;
    end else if (trap_evt) begin
      trap_reg <= 1'b1;                                    // [RULE23] [RULE1]
    end else if (s1_valid_reg && is_ack && s1_drive_reg) begin
      trap_reg <= 1'b0;
    end
  end

  assign trap_req_out = trap_reg;

  // Ack answer on own line until next strobe
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      ack_ad_reg <= '0;
      ack_oe_reg <= '0;
    end else if (s1_valid_reg && is_ack && s1_drive_reg) begin
      ack_ad_reg <= '0;
      ack_oe_reg <= '0;
      ack_ad_reg[unit_number_field] <= trap_reg;           // [RULE27]
      ack_oe_reg[unit_number_field] <= 1'b1;
    end else if (addr_strobe_in) begin
      ack_ad_reg <= '0;
      ack_oe_reg <= '0;
    end
  end

  assign ack_ad_out = ack_ad_reg;
  assign ack_ad_oe_out = ack_oe_reg;

  // ============================================================
  // Fault capture registers
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      fseg_reg <= '0;
      foff_reg <= '0;
      cyc_reg <= '0;
      lfetch_reg <= '0;
    end else if (first_event) begin
      fseg_reg <= s1_seg_reg;                              // [RULE21]
      foff_reg <= s1_off_reg;
      cyc_reg <= {s1_st_reg, 2'b00, s1_rd_reg, s1_ns_reg}; // [RULE22]
      lfetch_reg <= fetch_shadow_reg;                      // [RULE20]
    end
  end

  // Shadow updates after capture so a faulting fetch keeps the prior one
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      fetch_shadow_reg <= '0;
    end else if (access && is_fetch) begin
      fetch_shadow_reg <= {s1_seg_reg, s1_off_reg};
    end
  end

  // Data count: fetch clears, abort freezes
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      count_reg <= '0;
      count_lock_reg <= 1'b0;
    end else begin
      if (abort_evt) begin
        count_lock_reg <= 1'b1;                            // [RULE19]
      end else if (s1_valid_reg && is_ack && s1_drive_reg) begin
        count_lock_reg <= 1'b0;
      end
      if (!count_lock_reg && !abort_evt) begin
        if (clean_access && is_fetch) begin
          count_reg <= '0;
        end else if (clean_access) begin
          count_reg <= count_reg + 4'h1;                   // [RULE19]
        end
      end
    end
  end

  // ============================================================
  // Command port decode
  logic cmd_wr;
  logic cmd_rd;
  logic desc_access;
  logic attr_access;
  logic [7:0] cause_set;
  logic [7:0] cause_clr;

  assign cmd_wr = cmd_valid_in && cmd_write_in;
  assign cmd_rd = cmd_valid_in && !cmd_write_in;
  assign desc_access = cmd_valid_in && (cmd_sel_in == SEL_DESC);
  assign attr_access = cmd_valid_in && (cmd_sel_in == SEL_ATTR);

  // Table write port driven straight from the command
  assign tbl.wr_en = cmd_wr && (desc_access || attr_access);
  assign tbl.wr_attr_only = attr_access;
  assign tbl.wr_byte = dbyte_reg;                          // [RULE18]
  assign tbl.wr_idx = dptr_reg;                            // [RULE17]
  assign tbl.wr_data = cmd_wdata_in;
  assign tbl.rd_idx = dptr_reg;

  // Mode register
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      mode_reg <= RESET_BYTE;
    end else if (cmd_wr && cmd_sel_in == SEL_MODE) begin
      mode_reg <= cmd_wdata_in & MODE_MASK;
    end
  end

  // Pointer and byte counter with auto-increment
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      dptr_reg <= '0;
      dbyte_reg <= '0;
    end else if (cmd_wr && cmd_sel_in == SEL_DPTR) begin
      dptr_reg <= cmd_wdata_in[DESC_IDX_W-1:0];
    end else if (cmd_wr && cmd_sel_in == SEL_DBYTE) begin
      dbyte_reg <= cmd_wdata_in[1:0];
    end else if (desc_access) begin
      // Last byte of a descriptor steps to the next one [RULE17] [RULE18]
      dbyte_reg <= dbyte_reg + 2'h1;
      if (dbyte_reg == 2'h3) begin
        dptr_reg <= dptr_reg + 6'h01;
      end
    end else if (attr_access) begin
      dptr_reg <= dptr_reg + 6'h01;                        // [RULE17]
    end
  end

  // Cause flags: write one to clear, hardware set wins
  always_comb begin
    cause_set = '0;
    cause_set[CAUSE_WP] = viol_wp;
    cause_set[CAUSE_SYS] = viol_sys;
    cause_set[CAUSE_EXC] = viol_exc;
    cause_set[CAUSE_FAULT] = page_fault;
    cause_set[CAUSE_WARN] = warn;
    cause_clr = (cmd_wr && cmd_sel_in == SEL_CAUSE) ? cmd_wdata_in : '0;
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      cause_reg <= RESET_BYTE;
    end else begin
      cause_reg <= (cause_reg & ~cause_clr) | cause_set;   // [RULE23]
    end
  end

  // ============================================================
  // Registered read data
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      rdata_reg <= RESET_BYTE;
    end else if (cmd_rd) begin
      unique case (cmd_sel_in)
        SEL_MODE: rdata_reg <= mode_reg;
        SEL_DPTR: rdata_reg <= {2'b00, dptr_reg};
        SEL_DBYTE: rdata_reg <= {6'h00, dbyte_reg};
        // Whole descriptor byte chosen by the counter [RULE18]
        SEL_DESC: rdata_reg <= tbl.rd_word[{~dbyte_reg, 3'b000} +: 8];
        // Undefined top bit returned as zero [RULE6]
        SEL_ATTR: rdata_reg <= {1'b0, tbl.rd_word[ATTR_W-1:0]};
        SEL_CAUSE: rdata_reg <= cause_reg;
        SEL_FSEG: rdata_reg <= {1'b0, fseg_reg};
        SEL_FOFF_HI: rdata_reg <= foff_reg[15:8];
        SEL_FOFF_LO: rdata_reg <= foff_reg[7:0];
        SEL_LF_SEG: rdata_reg <= {1'b0, lfetch_reg[22:16]};
        SEL_LF_HI: rdata_reg <= lfetch_reg[15:8];
        SEL_LF_LO: rdata_reg <= lfetch_reg[7:0];
        SEL_CYC: rdata_reg <= cyc_reg;
        SEL_CNT: rdata_reg <= {4'h0, count_reg};
        // Unmapped selects read zero
        default: rdata_reg <= RESET_BYTE;
      endcase
    end
  end

  assign cmd_rdata_out = rdata_reg;
endmodule
`default_nettype wire

// ---- testbench/pmdp_unit_checker.sv ----
`default_nettype none
// ==========
// Port checks; mode byte shadowed
module pmdp_unit_checker
  import pmdp_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic chip_enable_in,
  input wire logic addr_strobe_in,
  input wire logic [6:0] seg_in,
  input wire logic [15:0] offset_in,
  input wire logic [3:0] status_in,
  input wire logic normal_mode_in,
  input wire logic [15:0] phys_addr_out,
  input wire logic phys_addr_oe_out,
  input wire logic abort_req_out,
  input wire logic trap_req_out,
  input wire logic suppress_out,
  input wire logic [7:0] ack_ad_oe_out,
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire logic [3:0] cmd_sel_in,
  input wire logic [7:0] cmd_wdata_in
);
  logic [7:0] mode_reg; // Copy of the mode byte
  logic [15:0] pass_reg; // Expected pass address
  logic side_ok;
  logic go;
  assign side_ok = !mode_reg[MODE_MULTI] || (normal_mode_in == mode_reg[MODE_SIDE]);
  assign go = addr_strobe_in && chip_enable_in && mode_reg[MODE_MASTER] && side_ok;
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      mode_reg <= 8'h00;
    end else if (cmd_valid_in && cmd_write_in && cmd_sel_in == SEL_MODE) begin
      mode_reg <= cmd_wdata_in & MODE_MASK;
    end
  end
  // Kept per strobe; lines are released after
  always_ff @(posedge clk_in) begin
    if (addr_strobe_in) begin
      pass_reg <= {1'b0, seg_in, offset_in[15:8]};
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_abort;
    abort_req_out [*4] ##1 !abort_req_out;
  endsequence
  a_abort_four_long: assert property ($rose(abort_req_out) |-> s_abort)
    else $error("abort length wrong");
  a_suppress_with_abort: assert property (suppress_out == abort_req_out)
    else $error("suppress not abort");
  a_trap_with_abort: assert property ($rose(abort_req_out) |-> trap_req_out)
    else $error("abort without trap");
  a_ce_low_quiet: assert property (addr_strobe_in && !chip_enable_in |-> ##2 !$rose(abort_req_out))
    else $error("abort while not selected");
  a_master_off_float: assert property (addr_strobe_in && !mode_reg[MODE_MASTER] |-> ##3 !phys_addr_oe_out)
    else $error("driven while off");
  a_side_miss_float: assert property (addr_strobe_in && !side_ok |-> ##3 !phys_addr_oe_out)
    else $error("driven on wrong side");
  a_pass_addr_exact: assert property (go && !mode_reg[MODE_RELOC] |-> ##2 phys_addr_out == pass_reg)
    else $error("bad pass address");
  a_ack_line_drive: assert property (go && mode_reg[MODE_RELOC] && status_in == ST_TRAP_ACK |-> ##2 ack_ad_oe_out[mode_reg[2:0]] && !trap_req_out)
    else $error("bad ack line");
endmodule
bind pmdp_unit pmdp_unit_checker i_chk(.*);
`default_nettype wire

// ---- testbench/pmdp_cpu_model.sv ----
`default_nettype none
// ==========
// Processor bus, one cycle per call
module pmdp_cpu_model (
  input wire logic clk_in,
  output logic strobe_out,
  output logic ce_out,
  output logic [6:0] seg_out,
  output logic [15:0] off_out,
  output logic [3:0] st_out,
  output logic rd_out,
  output logic nrm_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {strobe_out, ce_out, seg_out, off_out, st_out, rd_out, nrm_out} = '0;
  task automatic cycle(input logic [29:0] v);
    @(posedge clk_in);
    #1;
    {ce_out, seg_out, off_out, st_out, rd_out, nrm_out, strobe_out} = {v, 1'b1};
    @(posedge clk_in);
    #1;
    strobe_out = 1'b0;
    // Released lines show the inverse
    {seg_out, off_out} = ~{seg_out, off_out};
  endtask
endmodule
`default_nettype wire

// ---- testbench/pmdp_unit_bench.sv ----
`default_nettype none
module pmdp_unit_bench import pmdp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0, reset_n_in = 1'b0, cmd_valid_in = 1'b0, cmd_write_in = 1'b0;
  logic [3:0] cmd_sel_in = 4'h0, status_in;
  logic [7:0] cmd_wdata_in = 8'h00, cmd_rdata_out, ack_ad_out, ack_ad_oe_out;
  logic addr_strobe_in, chip_enable_in, read_not_write_in, normal_mode_in;
  logic abort_req_out, trap_req_out, suppress_out, phys_addr_oe_out;
  logic [6:0] seg_in;
  logic [15:0] offset_in, phys_addr_out;
  int n_fail = 0, comparisons = 0;
  localparam logic [31:0] WORD = {12'h0a3, 13'h1abc, 7'h41};
  localparam logic [29:0] RD5 = {1'b1, 7'h05, 16'h1a55, 4'h8, 2'b10};
  always #10 clk_in = ~clk_in;
  pmdp_cpu_model i_cpu(.clk_in(clk_in), .strobe_out(addr_strobe_in), .ce_out(chip_enable_in),
    .seg_out(seg_in), .off_out(offset_in), .st_out(status_in), .rd_out(read_not_write_in),
    .nrm_out(normal_mode_in));
  pmdp_unit i_dut(.*);
  task automatic close_out();
    if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Commands two cycles apart
  task automatic cmd(input logic w, input logic [3:0] s, input logic [7:0] d);
    @(posedge clk_in);
    #1;
    {cmd_valid_in, cmd_write_in, cmd_sel_in, cmd_wdata_in} = {1'b1, w, s, d};
    @(posedge clk_in);
    #1;
    cmd_valid_in = 1'b0;
  endtask
  task automatic rdc(input logic [3:0] s, input logic [7:0] e);
    cmd(1'b0, s, 8'h00);
    @(posedge clk_in);
    #1;
    chk($sformatf("select %0d", s), 16'(e), 16'(cmd_rdata_out));
  endtask
  // Flags: abort, suppress, trap
  task automatic bus(input logic [29:0] v, input logic [15:0] pa, input logic [2:0] f);
    i_cpu.cycle(v);
    repeat (2) @(posedge clk_in);
    #1;
    chk("flags", 16'(f), 16'({abort_req_out, suppress_out, trap_req_out}));
    if (pa != 16'hffff) chk("address", pa, phys_addr_out);
  endtask
  initial begin
    #200000;
    n_fail++;
    close_out();
  end
  initial begin
    repeat (4) @(posedge clk_in);
    #1;
    reset_n_in = 1'b1;
    rdc(SEL_MODE, 8'h00);
    cmd(1'b1, SEL_MODE, 8'hff);
    rdc(SEL_MODE, 8'hf7);
    bus(RD5, 16'hffff, 3'b000);
    cmd(1'b1, SEL_MODE, 8'h80);
    bus(RD5, 16'h051a, 3'b000);
    cmd(1'b1, SEL_MODE, 8'hc5);
    cmd(1'b1, SEL_DPTR, 8'h00);
    for (int i = 0; i < 64; i++) cmd(1'b1, SEL_ATTR, 8'h80);
    cmd(1'b1, SEL_DPTR, 8'h02);
    cmd(1'b1, SEL_DBYTE, 8'h00);
    for (int i = 0; i < 4; i++) cmd(1'b1, SEL_DESC, WORD[31-8*i -: 8]);
    rdc(SEL_DPTR, 8'h03);
    cmd(1'b1, SEL_DPTR, 8'h02);
    for (int i = 0; i < 4; i++) rdc(SEL_DESC, WORD[31-8*i -: 8]);
    bus(RD5, {13'h1abc, 3'h2}, 3'b000);
    cmd(1'b1, SEL_DPTR, 8'h02);
    rdc(SEL_ATTR, 8'h61);
    bus({RD5[29:2], 2'b00}, 16'hffff, 3'b111);
    rdc(SEL_CAUSE, 8'h01);
    rdc(SEL_FSEG, 8'h05);
    rdc(SEL_FOFF_HI, 8'h1a);
    rdc(SEL_FOFF_LO, 8'h55);
    rdc(SEL_CYC, 8'h80);
    rdc(SEL_CNT, 8'h01);
    bus({1'b1, 7'h00, 16'h0000, ST_TRAP_ACK, 2'b10}, 16'hffff, 3'b000);
    chk("ack lines", 16'h2020, {ack_ad_oe_out, ack_ad_out});
    cmd(1'b1, SEL_CAUSE, 8'h1f);
    bus({1'b1, 7'h06, 16'h0000, 4'h8, 2'b10}, 16'hffff, 3'b111);
    rdc(SEL_CAUSE, 8'h08);
    bus({1'b0, 7'h06, 16'h0000, 4'h8, 2'b10}, 16'hffff, 3'b001);
    close_out();
  end
endmodule
`default_nettype wire
